// >>> spd_pkg.sv
// Constants, types and default contents of the presence-detect array.
// Assumes a 100 MHz system clock; every cycle count below is derived from it.
package spd_pkg;

  localparam int CLK_MHZ = 100;
  // Internal programming time after a write sequence, longest.
  localparam int PROG_TIME_MS = 10;
  localparam int PROG_CYC = PROG_TIME_MS * CLK_MHZ * 1000;
  // Minimum delay from clock high to a qualifying data edge, least.
  localparam int QUAL_NS = 50;
  localparam logic [3:0] QUAL_CYC = 4'((QUAL_NS * CLK_MHZ + 999) / 1000);

  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam int PAGE_BYTES = 16;
  localparam int ARRAY_BYTES = 256;

  // (R8) (R9) Header size codes.
  localparam logic [7:0] OFS_USED = 8'h00, VAL_USED = 8'h80;
  localparam logic [7:0] OFS_SIZE = 8'h01, VAL_SIZE = 8'h08;
  localparam logic [7:0] OFS_MTYPE = 8'h02, VAL_MTYPE = 8'h07;
  // (R10) Row and column counts.
  localparam logic [7:0] OFS_ROWS = 8'h03, VAL_ROWS12 = 8'h0C, VAL_ROWS13 = 8'h0D;
  localparam logic [7:0] OFS_COLS = 8'h04, VAL_COLS = 8'h0A;
  // (R11) Two physical ranks.
  localparam logic [7:0] OFS_RANKS = 8'h05, VAL_RANKS = 8'h02;
  // (R12) Data width bytes.
  localparam logic [7:0] OFS_WID_LO = 8'h06, VAL_WID_LO = 8'h20;
  localparam logic [7:0] OFS_WID_HI = 8'h07, VAL_WID_HI = 8'h00;
  // (R20) Interface level code.
  localparam logic [7:0] OFS_LEVEL = 8'h08, VAL_LEVEL = 8'h04;
  // (R13) Cycle and access codes.
  localparam logic [7:0] OFS_TCK_A = 8'h09, VAL_TCK_A_F = 8'h60, VAL_TCK_A_S = 8'h75;
  localparam logic [7:0] OFS_TAC_A = 8'h0A, VAL_TAC_A_F = 8'h70, VAL_TAC_A_S = 8'h75;
  localparam logic [7:0] OFS_CFG = 8'h0B, VAL_CFG = 8'h00;
  localparam logic [7:0] OFS_REFR = 8'h0C, VAL_REFR12 = 8'h80, VAL_REFR13 = 8'h82;
  localparam logic [7:0] OFS_DWID = 8'h0D, VAL_DWID = 8'h08;
  // (R19) No check data.
  localparam logic [7:0] OFS_CHK = 8'h0E, VAL_CHK = 8'h00;
  // (R15) Column access delay.
  localparam logic [7:0] OFS_CCD = 8'h0F, VAL_CCD = 8'h01;
  localparam logic [7:0] OFS_BURST = 8'h10, VAL_BURST = 8'h0E;
  // (R14) Four device banks.
  localparam logic [7:0] OFS_BANKS = 8'h11, VAL_BANKS = 8'h04;
  localparam logic [7:0] OFS_CL = 8'h12, VAL_CL = 8'h0C;
  localparam logic [7:0] OFS_CSL = 8'h13, VAL_CSL = 8'h01;
  localparam logic [7:0] OFS_WEL = 8'h14, VAL_WEL = 8'h02;
  localparam logic [7:0] OFS_MATTR = 8'h15, VAL_MATTR = 8'h20;
  // (R18) General device attributes.
  localparam logic [7:0] OFS_DATTR = 8'h16, VAL_DATTR = 8'hC0;
  localparam logic [7:0] OFS_TCK_B = 8'h17, VAL_TCK_B_F = 8'h75, VAL_TCK_B_S = 8'hA0;
  localparam logic [7:0] OFS_TAC_B = 8'h18, VAL_TAC_B_F = 8'h70, VAL_TAC_B_S = 8'h75;
  localparam logic [7:0] OFS_TCK_C = 8'h19, VAL_TCK_C = 8'h00;
  localparam logic [7:0] OFS_TAC_C = 8'h1A, VAL_TAC_C = 8'h00;
  // (R16) Precharge delay, quarter nanoseconds.
  localparam logic [7:0] OFS_TRP = 8'h1B, VAL_TRP_F = 8'h48, VAL_TRP_S = 8'h50;
  localparam logic [7:0] OFS_TRRD = 8'h1C, VAL_TRRD_F = 8'h30, VAL_TRRD_S = 8'h3C;
  // (R16) Row to column delay.
  localparam logic [7:0] OFS_TRCD = 8'h1D, VAL_TRCD_F = 8'h48, VAL_TRCD_S = 8'h50;
  // (R17) Row active width.
  localparam logic [7:0] OFS_TRAS = 8'h1E, VAL_TRAS_F = 8'h2A, VAL_TRAS_S = 8'h2D;
  localparam logic [7:0] OFS_DENS = 8'h1F, VAL_DENS12 = 8'h10, VAL_DENS13 = 8'h20;

  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_DEV   = 7'h02,
    S_ACK   = 7'h04,
    S_ADDR  = 7'h08,
    S_WDATA = 7'h10,
    S_RDATA = 7'h20,
    S_RACK  = 7'h40
  } spd_state_t;

  typedef struct packed {
    logic             scl_m;
    logic             scl_s;
    logic             scl_d;
    logic             sda_m;
    logic             sda_s;
    logic             sda_d;
    logic [2:0]       sa_m;
    logic [2:0]       sa_s;
    logic             wc_m;
    logic             wc_s;
    logic [3:0]       high_cnt;
    spd_state_t       state;
    spd_state_t       after;
    logic [2:0]       bitcnt;
    logic [7:0]       shreg;
    logic [7:0]       ptr;
    logic             do_ack;
    logic             ack_on;
    logic             mack;
    logic [15:0][7:0] page;
    logic [15:0]      pvalid;
    logic [3:0]       pbase;
    logic [19:0]      busy_cnt;
    logic             sda_oe;
    logic             busy;
  } spd_regs_t;

  // Default content; row13 picks the larger array, fast the faster grade.
  function automatic logic [7:0] spd_rom_byte(input logic [7:0] a, input logic row13,
                                             input logic fast);
    case (a)
      OFS_USED:   return VAL_USED;
      OFS_SIZE:   return VAL_SIZE;
      OFS_MTYPE:  return VAL_MTYPE;
      OFS_ROWS:   return row13 ? VAL_ROWS13 : VAL_ROWS12;
      OFS_COLS:   return VAL_COLS;
      OFS_RANKS:  return VAL_RANKS;
      OFS_WID_LO: return VAL_WID_LO;
      OFS_WID_HI: return VAL_WID_HI;
      OFS_LEVEL:  return VAL_LEVEL;
      OFS_TCK_A:  return fast ? VAL_TCK_A_F : VAL_TCK_A_S;
      OFS_TAC_A:  return fast ? VAL_TAC_A_F : VAL_TAC_A_S;
      OFS_CFG:    return VAL_CFG;
      OFS_REFR:   return row13 ? VAL_REFR13 : VAL_REFR12;
      OFS_DWID:   return VAL_DWID;
      OFS_CHK:    return VAL_CHK;
      OFS_CCD:    return VAL_CCD;
      OFS_BURST:  return VAL_BURST;
      OFS_BANKS:  return VAL_BANKS;
      OFS_CL:     return VAL_CL;
      OFS_CSL:    return VAL_CSL;
      OFS_WEL:    return VAL_WEL;
      OFS_MATTR:  return VAL_MATTR;
      OFS_DATTR:  return VAL_DATTR;
      OFS_TCK_B:  return fast ? VAL_TCK_B_F : VAL_TCK_B_S;
      OFS_TAC_B:  return fast ? VAL_TAC_B_F : VAL_TAC_B_S;
      OFS_TCK_C:  return VAL_TCK_C;
      OFS_TAC_C:  return VAL_TAC_C;
      OFS_TRP:    return fast ? VAL_TRP_F : VAL_TRP_S;
      OFS_TRRD:   return fast ? VAL_TRRD_F : VAL_TRRD_S;
      OFS_TRCD:   return fast ? VAL_TRCD_F : VAL_TRCD_S;
      OFS_TRAS:   return fast ? VAL_TRAS_F : VAL_TRAS_S;
      OFS_DENS:   return row13 ? VAL_DENS13 : VAL_DENS12;
      default:    return 8'h00;
    endcase
  endfunction : spd_rom_byte

endpackage : spd_pkg

// >>> spd_eeprom.sv
// Presence-detect EEPROM: two-wire bus slave serving a 256-byte array.
// Assumes open-drain SCL/SDA pins from outside, sampled by i_mclk.
//
// Contract
// (R1) Current read: start, select with read bit one, one byte from pointer.
// (R2) Random read: select write, address, restart, select read, byte returned.
// (R3) Sequential read keeps sending successive bytes while master acknowledges.
// (R4) Byte write stores one byte only with write control low.
// (R5) Page write: up to sixteen bytes after one address, one program cycle.
// (R6) After a write, programming lasts at most 10 ms before next start.
// (R7) Data edges too soon after clock rises are not start or stop.
// (R8) Byte 0 reads 0x80, 128 description bytes.
// (R9) Byte 1 reads 0x08, array of 256 bytes.
// (R10) Byte 3 gives 0x0C or 0x0D rows; byte 4 gives 0x0A columns.
// (R11) Rank count byte reads 0x02.
// (R12) Bytes 6 and 7 read 0x20 and 0x00, 32-bit width.
// (R13) Access and cycle time bytes use two-digit decimal codes.
// (R14) Byte 17 reads 0x04, four banks.
// (R15) Byte 15 reads 0x01, one clock column delay.
// (R16) Precharge and row-to-column bytes in quarter ns, 0x48 or 0x50.
// (R17) Row active width byte 0x2A fast grade, 0x2D slow grade.
// (R18) General attributes byte reads 0xC0.
// (R19) Byte 14 reads 0x00, no check data.
// (R20) Byte 8 reads 0x04, 2.5 V terminated level.
// (R21) Select byte MSB first: type code, slot address bits, read bit last.
// (R22) Reads release data after eight bits; no acknowledge ends transmission.
// (R23) Byte pointer advances by one after each byte read or written; writes wrap within the 16-byte page here.
`timescale 1ns/10ps
module spd_eeprom #(
  parameter int PROG_CYCLES = spd_pkg::PROG_CYC,
  parameter bit ROW13       = 1'b0,
  parameter bit FAST        = 1'b1
) (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst,
  // Two-wire bus pins
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_out,
  output logic      o_sda_oe,
  // Straps and write protection
  input  wire logic i_slot_address_bit0,
  input  wire logic i_slot_address_bit1,
  input  wire logic i_slot_address_bit2,
  input  wire logic i_write_control_input,
  // Status
  output logic      o_write_busy
);

  spd_pkg::spd_regs_t r;
  spd_pkg::spd_regs_t next_r;
  logic [7:0]         mem [spd_pkg::ARRAY_BYTES];
  logic [7:0]         rd_byte;
  logic [7:0]         rx;
  logic               qual;
  logic               start_det;
  logic               stop_det;
  logic               scl_rise;
  logic               scl_fall;
  logic               commit;

  assign rd_byte = mem[r.ptr];
  assign rx = {r.shreg[6:0], r.sda_s};
  assign scl_rise = r.scl_s && !r.scl_d;
  assign scl_fall = !r.scl_s && r.scl_d;
  // (R7) start stop filter
  assign qual = r.scl_s && r.scl_d && (r.high_cnt >= spd_pkg::QUAL_CYC);
  assign start_det = qual && r.sda_d && !r.sda_s;
  assign stop_det = qual && !r.sda_d && r.sda_s;
  assign commit = stop_det && (|r.pvalid);

  always_comb begin
    next_r = r;
    next_r.scl_m = i_scl;
    next_r.scl_s = r.scl_m;
    next_r.scl_d = r.scl_s;
    next_r.sda_m = i_sda;
    next_r.sda_s = r.sda_m;
    next_r.sda_d = r.sda_s;
    next_r.sa_m = {i_slot_address_bit2, i_slot_address_bit1, i_slot_address_bit0};
    next_r.sa_s = r.sa_m;
    next_r.wc_m = i_write_control_input;
    next_r.wc_s = r.wc_m;
    // Count how long the clock has been high, saturating.
    if (!r.scl_s) begin
      next_r.high_cnt = 4'h0;
    end else if (r.high_cnt != 4'hF) begin
      next_r.high_cnt = r.high_cnt + 4'h1;
    end
    if (r.busy_cnt != 20'h00000) begin
      next_r.busy_cnt = r.busy_cnt - 20'h00001;
    end
    if (stop_det) begin
      next_r.state = spd_pkg::S_IDLE;
      next_r.sda_oe = 1'b0;
      // (R5) page commit
      if (|r.pvalid) begin
        next_r.pvalid = 16'h0000;
        // (R6) program time
        next_r.busy_cnt = 20'(PROG_CYCLES);
      end
    end else if (start_det) begin
      // A restart abandons any bytes gathered without a stop.
      next_r.state = spd_pkg::S_DEV;
      next_r.bitcnt = 3'h0;
      next_r.sda_oe = 1'b0;
      next_r.pvalid = 16'h0000;
    end else begin
      case (r.state)
        spd_pkg::S_IDLE: begin
          next_r.sda_oe = 1'b0;
        end
        spd_pkg::S_DEV: begin
          if (scl_rise) begin
            next_r.shreg = rx;
            next_r.bitcnt = r.bitcnt + 3'h1;
            if (r.bitcnt == 3'h7) begin
              next_r.state = spd_pkg::S_ACK;
              next_r.ack_on = 1'b0;
              // (R21) select match
              if (rx[7:1] == {spd_pkg::DEV_TYPE, r.sa_s} && !r.busy) begin
                next_r.do_ack = 1'b1;
                // (R1) read select
                next_r.after = rx[0] ? spd_pkg::S_RDATA : spd_pkg::S_ADDR;
              end else begin
                // (R6) busy refuses select
                next_r.do_ack = 1'b0;
                next_r.after = spd_pkg::S_IDLE;
              end
            end
          end
        end
        spd_pkg::S_ADDR: begin
          if (scl_rise) begin
            next_r.shreg = rx;
            next_r.bitcnt = r.bitcnt + 3'h1;
            if (r.bitcnt == 3'h7) begin
              // (R2) word address
              next_r.ptr = rx;
              next_r.pbase = rx[7:4];
              next_r.state = spd_pkg::S_ACK;
              next_r.ack_on = 1'b0;
              next_r.do_ack = 1'b1;
              next_r.after = spd_pkg::S_WDATA;
            end
          end
        end
        spd_pkg::S_WDATA: begin
          if (scl_rise) begin
            next_r.shreg = rx;
            next_r.bitcnt = r.bitcnt + 3'h1;
            if (r.bitcnt == 3'h7) begin
              next_r.state = spd_pkg::S_ACK;
              next_r.ack_on = 1'b0;
              // (R4) write control gate
              if (!r.wc_s) begin
                next_r.page[r.ptr[3:0]] = rx;
                next_r.pvalid[r.ptr[3:0]] = 1'b1;
                // (R23) write pointer step
                next_r.ptr = {r.ptr[7:4], r.ptr[3:0] + 4'h1};
                next_r.do_ack = 1'b1;
                next_r.after = spd_pkg::S_WDATA;
              end else begin
                next_r.do_ack = 1'b0;
                next_r.after = spd_pkg::S_IDLE;
              end
            end
          end
        end
        spd_pkg::S_ACK: begin
          if (scl_fall) begin
            if (!r.ack_on) begin
              next_r.ack_on = 1'b1;
              next_r.sda_oe = r.do_ack;
            end else begin
              next_r.ack_on = 1'b0;
              next_r.state = r.after;
              next_r.bitcnt = 3'h0;
              next_r.sda_oe = 1'b0;
              if (r.after == spd_pkg::S_RDATA) begin
                next_r.shreg = rd_byte;
                next_r.sda_oe = !rd_byte[7];
              end
            end
          end
        end
        spd_pkg::S_RDATA: begin
          if (scl_fall) begin
            next_r.bitcnt = r.bitcnt + 3'h1;
            if (r.bitcnt == 3'h7) begin
              // (R22) release after eight
              next_r.sda_oe = 1'b0;
              // (R23) read pointer step
              next_r.ptr = r.ptr + 8'h01;
              next_r.state = spd_pkg::S_RACK;
              next_r.mack = 1'b0;
            end else begin
              next_r.shreg = {r.shreg[6:0], 1'b0};
              next_r.sda_oe = !r.shreg[6];
            end
          end
        end
        spd_pkg::S_RACK: begin
          if (scl_rise) begin
            // (R22) no acknowledge ends
            if (r.sda_s) begin
              next_r.state = spd_pkg::S_IDLE;
            end else begin
              next_r.mack = 1'b1;
            end
          end else if (scl_fall && r.mack) begin
            // (R3) next sequential byte
            next_r.mack = 1'b0;
            next_r.state = spd_pkg::S_RDATA;
            next_r.bitcnt = 3'h0;
            next_r.shreg = rd_byte;
            next_r.sda_oe = !rd_byte[7];
          end
        end
        default: begin
          next_r.state = spd_pkg::S_IDLE;
          next_r.sda_oe = 1'b0;
        end
      endcase
    end
    next_r.busy = (next_r.busy_cnt != 20'h00000);
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      r <= '0;
      r.state <= spd_pkg::S_IDLE;
      r.after <= spd_pkg::S_IDLE;
      // Both lines idle high, so the edge detectors see no false edge after reset.
      r.scl_m <= 1'b1;
      r.scl_s <= 1'b1;
      r.scl_d <= 1'b1;
      r.sda_m <= 1'b1;
      r.sda_s <= 1'b1;
      r.sda_d <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Reset reloads the description; writes may later overwrite any byte.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      for (int i = 0; i < spd_pkg::ARRAY_BYTES; i++) begin
        mem[i] <= spd_pkg::spd_rom_byte(8'(i), ROW13, FAST);
      end
    end else if (commit) begin
      // (R5) one program cycle
      for (int j = 0; j < spd_pkg::PAGE_BYTES; j++) begin
        if (r.pvalid[j]) begin
          mem[{r.pbase, 4'(j)}] <= r.page[j];
        end
      end
    end
  end

  // Open drain: the pin only ever pulls low.
  assign o_sda_out = 1'b0;
  assign o_sda_oe = r.sda_oe;
  assign o_write_busy = r.busy;

  a_rom_header: assert property ( // R8 R9
    @(posedge i_mclk) disable iff (i_rst)
    $fell(i_rst) |-> mem[0] == 8'h80 && mem[1] == 8'h08)
    else $error("header bytes wrong after reset");

  a_rom_geometry: assert property ( // R10 R11 R12
    @(posedge i_mclk) disable iff (i_rst)
    $fell(i_rst) |-> mem[3] == (ROW13 ? 8'h0D : 8'h0C) && mem[4] == 8'h0A
      && mem[5] == 8'h02 && mem[6] == 8'h20 && mem[7] == 8'h00)
    else $error("geometry bytes wrong after reset");

  a_rom_timing: assert property ( // R13 R16 R17
    @(posedge i_mclk) disable iff (i_rst)
    $fell(i_rst) |-> mem[9] == (FAST ? 8'h60 : 8'h75)
      && mem[10] == (FAST ? 8'h70 : 8'h75) && mem[27] == (FAST ? 8'h48 : 8'h50)
      && mem[29] == (FAST ? 8'h48 : 8'h50) && mem[30] == (FAST ? 8'h2A : 8'h2D))
    else $error("timing bytes wrong after reset");

  a_rom_attrs: assert property ( // R14 R15 R18 R19 R20
    @(posedge i_mclk) disable iff (i_rst)
    $fell(i_rst) |-> mem[17] == 8'h04 && mem[15] == 8'h01 && mem[22] == 8'hC0
      && mem[14] == 8'h00 && mem[8] == 8'h04)
    else $error("attribute bytes wrong after reset");

  a_start_filter: assert property ( // R7
    @(posedge i_mclk) disable iff (i_rst)
    scl_rise |-> (!start_det && !stop_det) [*5])
    else $error("start or stop taken too soon after clock rise");

  a_select_nomatch: assert property ( // R21
    @(posedge i_mclk) disable iff (i_rst)
    r.state == spd_pkg::S_DEV && scl_rise && r.bitcnt == 3'h7 && !start_det
      && !stop_det && rx[7:1] != {spd_pkg::DEV_TYPE, r.sa_s} |=> !r.do_ack)
    else $error("foreign select acknowledged");

  a_read_first: assert property ( // R1
    @(posedge i_mclk) disable iff (i_rst)
    r.state == spd_pkg::S_ACK && r.ack_on && scl_fall && !start_det && !stop_det
      && r.after == spd_pkg::S_RDATA |=> r.state == spd_pkg::S_RDATA
      && r.sda_oe == !$past(rd_byte[7]))
    else $error("read byte not presented after select");

  a_addr_load: assert property ( // R2
    @(posedge i_mclk) disable iff (i_rst)
    r.state == spd_pkg::S_ADDR && scl_rise && r.bitcnt == 3'h7 && !start_det
      && !stop_det |=> r.ptr == $past(rx) ##1 r.state == spd_pkg::S_ACK)
    else $error("word address not loaded");

  a_wc_blocks: assert property ( // R4
    @(posedge i_mclk) disable iff (i_rst)
    r.state == spd_pkg::S_WDATA && scl_rise && r.bitcnt == 3'h7 && r.wc_s
      && !start_det && !stop_det |=> r.pvalid == $past(r.pvalid) && !r.do_ack)
    else $error("byte taken while write control high");

  a_prog_busy: assert property ( // R6
    @(posedge i_mclk) disable iff (i_rst)
    commit |=> r.busy && r.busy_cnt == 20'(PROG_CYCLES)
      ##1 r.busy_cnt == 20'(PROG_CYCLES - 1))
    else $error("programming cycle not started");

  a_busy_nack: assert property ( // R6
    @(posedge i_mclk) disable iff (i_rst)
    r.busy && r.state == spd_pkg::S_ACK && r.after == spd_pkg::S_IDLE |-> !r.do_ack)
    else $error("select acknowledged while programming");

  a_read_release: assert property ( // R22 R23
    @(posedge i_mclk) disable iff (i_rst)
    r.state == spd_pkg::S_RDATA && scl_fall && r.bitcnt == 3'h7 && !start_det
      && !stop_det |=> !r.sda_oe && r.state == spd_pkg::S_RACK
      && r.ptr == $past(r.ptr) + 8'h01)
    else $error("data line not released or pointer not advanced");

  a_master_nack: assert property ( // R22 R3
    @(posedge i_mclk) disable iff (i_rst)
    r.state == spd_pkg::S_RACK && scl_rise && !start_det && !stop_det
      |=> (r.state == spd_pkg::S_IDLE) == $past(r.sda_s))
    else $error("master acknowledge handled wrongly");

endmodule : spd_eeprom

// >>> spd_host_model.sv
// Behavioural two-wire bus master that drives the presence-detect slave.
// Assumes the bench resolves the data wire with a pull-up from all pull enables.
`timescale 1ns/10ps
module spd_host_model (
  // Bus pins
  output logic      o_scl,
  output logic      o_sda_pull,
  input  wire logic i_sda
);
  // A quarter of the 125 ns bus clock; the clock stands high between frames.
  localparam real QTR = 31.25;

  initial begin
    o_scl      = 1'b1;
    o_sda_pull = 1'b0;
  end

  task automatic bus_start();
    #QTR o_sda_pull = 1'b0;
    #QTR o_scl = 1'b1;
    #(2 * QTR) o_sda_pull = 1'b1;
    #(2 * QTR) o_scl = 1'b0;
  endtask : bus_start

  task automatic bus_stop();
    #QTR o_sda_pull = 1'b1;
    #QTR o_scl = 1'b1;
    #(2 * QTR) o_sda_pull = 1'b0;
    #(4 * QTR);
  endtask : bus_stop

  // early data edge after clock rise
  task automatic bus_bit(input logic b, input logic gl, output logic r);
    r = 1'b1;
    #QTR o_sda_pull = !b;
    #QTR o_scl = 1'b1;
    if (gl) begin
      // The edge lands well inside the qualification delay, so it must not count.
      #20 o_sda_pull = 1'b1;
      #(2 * QTR - 20);
    end else begin
      #QTR r = i_sda;
      #QTR;
    end
    o_scl = 1'b0;
  endtask : bus_bit

  task automatic tx_byte(input logic [7:0] d, input logic gl, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bus_bit(d[i], gl && (i == 7), r);
    end
    bus_bit(1'b1, 1'b0, r);
    ack = !r;
  endtask : tx_byte

  task automatic rx_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bus_bit(1'b1, 1'b0, r);
      d[i] = r;
    end
    bus_bit(!mack, 1'b0, r);
  endtask : rx_byte
endmodule : spd_host_model

// >>> spd_serial_eeprom_slave_tb.sv
// Self-checking bench for the presence-detect EEPROM against an array model.
// Assumes the host model above and a pull-up on the data wire.
`timescale 1ns/10ps
module spd_serial_eeprom_slave_tb;
  // Shortened programming time keeps the run brief.
  localparam int PROG = 400;
  localparam logic [255:0] ROM_LO =
    256'h8008070C0A022000_0460700080080001_0E040C010220C075_7000004830482A10;
  // Thirteen row bits and the slower grade, served by the second instance.
  localparam logic [255:0] ROM_ALT =
    256'h8008070D0A022000_0475750082080001_0E040C010220C0A0_750000503C502D20;

  logic       i_mclk = 1'b0;
  logic       i_rst  = 1'b1;
  logic [2:0] sa     = 3'h0;
  logic       wc     = 1'b1;
  logic       scl;
  logic       pull;
  logic       sda_out;
  logic       sda_oe;
  logic       sda_out2;
  logic       sda_oe2;
  logic       busy;
  wire        sda_line;
  int         errors   = 0;
  int         checked  = 0;
  int         seed     = 32'h24D4BF17;
  int         ptr      = 0;
  int         busy_cyc = 0;
  int         mem [256];

  assign sda_line = !((sda_oe && !sda_out) || (sda_oe2 && !sda_out2) || pull);
  always #5 i_mclk = !i_mclk;
  always @(posedge i_mclk) begin
    if (busy === 1'b1) busy_cyc <= busy_cyc + 1;
  end

  spd_eeprom #(.PROG_CYCLES(PROG), .ROW13(1'b0), .FAST(1'b1)) uut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_line),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .i_slot_address_bit0(sa[0]), .i_slot_address_bit1(sa[1]),
    .i_slot_address_bit2(sa[2]), .i_write_control_input(wc), .o_write_busy(busy));

  // Inverted straps keep it off every select meant for the first instance.
  spd_eeprom #(.PROG_CYCLES(PROG), .ROW13(1'b1), .FAST(1'b0)) uut2 (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_line),
    .o_sda_out(sda_out2), .o_sda_oe(sda_oe2),
    .i_slot_address_bit0(!sa[0]), .i_slot_address_bit1(!sa[1]),
    .i_slot_address_bit2(!sa[2]), .i_write_control_input(wc), .o_write_busy());

  spd_host_model h (.o_scl(scl), .o_sda_pull(pull), .i_sda(sda_line));

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check

  task automatic stop_test();
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // A negative address means a current-address read from the model pointer.
  task automatic rd(input int a, input int n, input logic gl);
    logic       ack;
    logic [7:0] d;
    if (a >= 0) begin
      h.bus_start();
      h.tx_byte({spd_pkg::DEV_TYPE, sa, 1'b0}, gl, ack);
      check("select ack", 1, ack);
      h.tx_byte(8'(a), 1'b0, ack);
      check("address ack", 1, ack);
      ptr = a;
    end
    h.bus_start();
    h.tx_byte({spd_pkg::DEV_TYPE, sa, 1'b1}, 1'b0, ack);
    check("read select ack", 1, ack);
    for (int k = 0; k < n; k++) begin
      h.rx_byte(k < n - 1, d);
      check("read byte", mem[ptr], d);
      ptr = (ptr + 1) % 256;
    end
    h.bus_stop();
    check("released after read", 0, sda_oe);
  endtask : rd

  task automatic wr(input int a, input int n);
    logic       ack;
    logic [7:0] d;
    h.bus_start();
    h.tx_byte({spd_pkg::DEV_TYPE, sa, 1'b0}, 1'b0, ack);
    check("write select ack", 1, ack);
    h.tx_byte(8'(a), 1'b0, ack);
    check("write address ack", 1, ack);
    for (int k = 0; k < n; k++) begin
      d = 8'($random(seed));
      h.tx_byte(d, 1'b0, ack);
      check("data ack", !wc, ack);
      if (!wc) mem[(a & 8'hF0) | ((a + k) & 8'h0F)] = d;
    end
    busy_cyc = 0;
    h.bus_stop();
    if (!wc) begin
      // Deliberately early select: it must be refused while programming.
      h.bus_start();
      h.tx_byte({spd_pkg::DEV_TYPE, sa, 1'b0}, 1'b0, ack);
      check("busy select ack", 0, ack);
      h.bus_stop();
    end
    for (int k = 0; k < PROG + 100 && (busy !== 1'b0 || k < 10); k++) begin
      @(negedge i_mclk);
    end
    check("write busy done", 0, busy);
    if (busy !== 1'b0) stop_test();
    if (!wc) check("program time", 1, busy_cyc > PROG / 2 && busy_cyc <= PROG);
  endtask : wr

  initial begin
    logic       ack;
    logic [7:0] sel;
    logic [7:0] d;
    for (int i = 0; i < 256; i++) begin
      mem[i] = (i < 32) ? ROM_LO[255 - 8 * i -: 8] : 0;
    end
    repeat (16) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst <= 1'b0;
    sa    <= 3'($random(seed));
    repeat (8) @(negedge i_mclk);
    check("reset data drive", 0, sda_oe);
    check("reset busy", 0, busy);
    rd(0, 32, 1'b1);
    rd(-1, 2, 1'b0);
    wr(5, 1);
    rd(5, 1, 1'b0);
    @(negedge i_mclk) wc <= 1'b0;
    wr(8'h40, 16);
    rd(8'h40, 17, 1'b0);
    wr(8'h7E, 18);
    rd(8'h70, 16, 1'b0);
    wr(8'h90, 1);
    rd(8'h8F, 3, 1'b0);
    // Each strap bit mismatched in turn, then the protection select code.
    for (int k = 0; k < 4; k++) begin
      sel = (k == 3) ? {4'h6, sa, 1'b0} : {spd_pkg::DEV_TYPE, sa ^ 3'(1 << k), 1'b0};
      h.bus_start();
      h.tx_byte(sel, 1'b0, ack);
      check("foreign select ack", 0, ack);
      h.bus_stop();
    end
    rd(-1, 2, 1'b0);
    // The second instance is read from its reset pointer in one sequence.
    h.bus_start();
    h.tx_byte({spd_pkg::DEV_TYPE, ~sa, 1'b1}, 1'b0, ack);
    check("variant select ack", 1, ack);
    for (int k = 0; k < 32; k++) begin
      h.rx_byte(k < 31, d);
      check("variant byte", ROM_ALT[255 - 8 * k -: 8], d);
    end
    h.bus_stop();
    stop_test();
  end
endmodule : spd_serial_eeprom_slave_tb
